/* core/gfc_pkg.sv */
// Shared constants for the gated frequency counter card
package gfc_pkg;
  // ------------------------------------------------------------
  // Host port map (byte offsets from the switch-selected base)
  // ------------------------------------------------------------
  localparam int         ADDR_W   = 10;
  localparam logic [1:0] OFS_DATA = 2'h0;
  localparam logic [1:0] OFS_CMD  = 2'h1;
  localparam logic [1:0] OFS_PIN  = 2'h2;
  localparam logic [1:0] OFS_POUT = 2'h3;
  localparam logic [7:0] BASE_MIN = 8'h40;  // Base 0x100 as a word-of-four index
  localparam logic [7:0] POUT_RST = 8'h00;

  // ------------------------------------------------------------
  // Data pointer: group and element codes
  // ------------------------------------------------------------
  localparam logic [2:0] GRP_FIRST   = 3'h1;
  localparam logic [2:0] GRP_LAST    = 3'h5;
  localparam logic [2:0] GRP_TB      = 3'h4;
  localparam logic [2:0] GRP_ACC     = 3'h5;
  localparam logic [2:0] GRP_CTRL    = 3'h7;
  localparam logic [1:0] ELEM_MODE   = 2'h0;
  localparam logic [1:0] ELEM_LOAD   = 2'h1;
  localparam logic [1:0] ELEM_MMODE  = 2'h2;
  localparam logic [1:0] ELEM_STATUS = 2'h3;
  localparam int         HOLD_BIT    = 1;     // Elements 2 and 3 address the hold register

  // ------------------------------------------------------------
  // Command byte layout
  // ------------------------------------------------------------
  localparam logic [2:0] OP_PTR    = 3'h0;
  localparam logic [2:0] OP_ARM    = 3'h1;
  localparam logic [2:0] OP_LOAD   = 3'h2;
  localparam logic [2:0] OP_LDARM  = 3'h3;
  localparam logic [2:0] OP_DSAVE  = 3'h4;
  localparam logic [2:0] OP_SAVE   = 3'h5;
  localparam logic [2:0] OP_DISARM = 3'h6;
  localparam logic [2:0] OP_MISC   = 3'h7;
  localparam logic [1:0] SUB_CLR   = 2'h0;
  localparam logic [1:0] SUB_SET   = 2'h1;
  localparam logic [1:0] SUB_STEP  = 2'h2;
  localparam logic [7:0] CMD_MRESET = 8'hFF;
  localparam int         NUM_CTR   = 5;
  localparam int         SEL_TB    = 3;       // Select/output bit of the timebase counter
  localparam int         SEL_ACC   = 4;       // Select/output bit of the accumulator
  localparam int         STAT_ERR  = 7;       // Status bit: last timebase load refused

  // ------------------------------------------------------------
  // Gate interval, source select, reset values
  // ------------------------------------------------------------
  localparam logic [15:0] GATE_MIN   = 16'h0001;
  localparam logic [15:0] GATE_MAX   = 16'h7FFF;
  localparam logic [15:0] WORD_RST   = 16'h0000;
  localparam int          SRC_W      = 4;
  localparam int          NUM_SRC    = 5;
  localparam int          NUM_GATE   = 4;
  localparam logic [3:0]  SRC_FIRST  = 4'h1;

  // ------------------------------------------------------------
  // Timing: 1 ms tick from the divided crystal at a 50 ns clock
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 50;
  localparam int TICK_PERIOD_NS = 1_000_000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
endpackage

/* core/gfc_regmem.sv */
// Word store for the counter mode, load and hold registers
`timescale 1ns/10ps
module gfc_regmem #(
  parameter int WIDTH  = 16,
  parameter int ADDR_W = 5
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Single port: write strobe, shared address
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [WIDTH-1:0]  wdata,
  output logic      [WIDTH-1:0]  rdata
);
  logic [WIDTH-1:0] mem [2**ADDR_W];

  // ------------------------------------------------------------
  // Storage: no reset on the array, software must load it
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // Registered read, follows the address one cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= we ? wdata : mem[addr];
    end
  end
endmodule

/* core/gfc_top.sv */
// Gated frequency counter card: host byte ports, timebase and accumulator
`timescale 1ns/10ps
// Overview of operation
// - Timebase counts down, reloads, toggles: high one interval, low one interval.
// - Timebase is stepped by the 1 ms divided-crystal tick.
// - Accumulator counts selected input edges only while its gate is high.
// - Accumulator gate is the timebase output.
// - Timebase output level is readable in the status byte.
// - Accumulator is 16 bits and wraps silently on overflow.
// - Gate interval 1 to 32767 ms; out of range loads are refused.
// - Source codes 1-5 pick source inputs, 6-9 pick gate inputs.
// - One input per measurement; result within three gate intervals.
// - Counters one to three are untouched by the measurement.
// - Count path takes inputs up to 7 MHz at 50 percent duty.
// - Four byte ports at a switch base between 0x100 and 0x3FC.
// - Offsets: chip data, command/status, parallel input, parallel output.
module gfc_top
  import gfc_pkg::*;
#(
  parameter int TICK_CYCLES = gfc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      arst_n,
  // Host byte port
  input  wire logic [gfc_pkg::ADDR_W-1:0] io_addr,
  input  wire logic                      io_rd,
  input  wire logic                      io_wr,
  input  wire logic [7:0]                io_din,
  output logic      [7:0]                io_dout,
  output logic                           io_dout_en,
  // Base address switches, address bits 9..2
  input  wire logic [7:0]                base_switch,
  // Field count inputs and timebase output
  input  wire logic [gfc_pkg::NUM_SRC-1:0]  count_src,
  input  wire logic [gfc_pkg::NUM_GATE-1:0] count_gate,
  output logic                           timebase_out,
  // Parallel digital I/O
  input  wire logic [7:0]                parallel_input_byte,
  output logic      [7:0]                parallel_output_byte
);
  import gfc_pkg::*;

  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [TW-1:0]        tick_cnt;
    logic [2:0]           grp;
    logic [1:0]           elem;
    logic                 bp;
    logic                 err;
    logic [NUM_CTR-1:0]   outs;
    logic                 arm_tb;
    logic                 arm_acc;
    logic [15:0]          cnt_tb;
    logic [15:0]          cnt_acc;
    logic [15:0]          load_tb;
    logic [15:0]          load_acc;
    logic [15:0]          hold_tb;
    logic [15:0]          hold_acc;
    logic [SRC_W-1:0]     src_sel;
    logic [15:0]          mmode;
    logic                 src_prev;
    logic [7:0]           dout;
    logic                 dout_en;
    logic [7:0]           pout;
  } gfc_state_t;

  gfc_state_t s;
  gfc_state_t next_s;
  logic [1:0] rst_sync;
  logic       rst_n;

  // ------------------------------------------------------------
  // Reset release through two flops
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ------------------------------------------------------------
  // Register word store for modes and loads of counters 1..5 and hold of counters 1..3
  // ------------------------------------------------------------
  logic        mem_we;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;

  gfc_regmem #(
    .WIDTH  (16),
    .ADDR_W (5)
  ) u_regmem (
    .clk   (mclk),
    .rst_n (rst_n),
    .we    (mem_we),
    .addr  ({s.grp, s.elem}),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  // ------------------------------------------------------------
  // Combinational helpers
  // ------------------------------------------------------------
  logic                         hit;
  logic                         rd;
  logic                         wr;
  logic [1:0]                   ofs;
  logic                         tick;
  logic                         src_now;
  logic [NUM_SRC+NUM_GATE-1:0]  src_vec;
  logic [15:0]                  word_cur;
  logic [7:0]                   status;
  logic                         grp_ctr;
  logic [NUM_CTR-1:0]           sel;
  logic [2:0]                   op;
  logic [2:0]                   nsel;
  logic                         tb_ev;
  logic                         acc_ev;
  logic                         load_bad;

  // Base decode: only bits 9..2 compared, so the base is always four-aligned
  assign hit = (io_addr[ADDR_W-1:2] == base_switch) && (base_switch >= BASE_MIN);
  assign rd  = io_rd && hit;
  assign wr  = io_wr && hit;
  assign ofs = io_addr[1:0];
  assign op  = io_din[7:5];
  assign nsel = io_din[2:0];
  assign sel = io_din[NUM_CTR-1:0];
  assign grp_ctr = (s.grp >= GRP_FIRST) && (s.grp <= GRP_LAST);
  assign tick = (s.tick_cnt == TICK_LAST);
  assign status = {s.err, 1'b0, s.outs, s.bp};
  assign src_vec = {count_gate, count_src};
  assign load_bad = (s.load_tb < GATE_MIN) || (s.load_tb > GATE_MAX);

  // Source mux: codes outside 1..9 select nothing, so nothing counts
  always_comb begin
    src_now = 1'b0;
    for (int i = 0; i < NUM_SRC + NUM_GATE; i++) begin
      if (s.src_sel == SRC_W'(i + 1)) begin
        src_now = src_vec[i];
      end
    end
  end

  // Word under the data pointer; hold of the measuring pair lives in flops
  always_comb begin
    word_cur = mem_rdata;
    if (s.grp == GRP_CTRL) begin
      word_cur = (s.elem == ELEM_STATUS) ? {8'h00, status} : s.mmode;
    end else if (s.elem[HOLD_BIT] && (s.grp == GRP_TB)) begin
      word_cur = s.hold_tb;
    end else if (s.elem[HOLD_BIT] && (s.grp == GRP_ACC)) begin
      word_cur = s.hold_acc;
    end
  end

  // ------------------------------------------------------------
  // Next state: counting first, then host accesses override
  // ------------------------------------------------------------
  always_comb begin
    next_s    = s;
    mem_we    = 1'b0;
    mem_wdata = s.bp ? {word_cur[15:8], io_din} : {io_din, word_cur[7:0]};
    tb_ev     = s.arm_tb && tick;
    acc_ev    = s.arm_acc && s.outs[SEL_TB] && src_now && !s.src_prev;
    next_s.dout_en  = 1'b0;
    next_s.src_prev = src_now;
    next_s.tick_cnt = tick ? '0 : s.tick_cnt + 1'b1;

    // Single-step commands force a count event, merging with a tick or edge in the same cycle
    if (wr && (ofs == OFS_CMD) && (op == OP_MISC) && (io_din[4:3] == SUB_STEP)) begin
      if (nsel == 3'(SEL_TB + 1)) begin
        tb_ev = 1'b1;
      end
      if (nsel == 3'(SEL_ACC + 1)) begin
        acc_ev = 1'b1;
      end
    end

    // Timebase: count down, reload and toggle at the terminal count
    if (tb_ev) begin
      if (s.cnt_tb <= GATE_MIN) begin
        next_s.cnt_tb          = s.load_tb;
        next_s.outs[SEL_TB]    = !s.outs[SEL_TB];
      end else begin
        next_s.cnt_tb = s.cnt_tb - 1'b1;
      end
    end

    // Accumulator: 16-bit up count, wraps with no overflow record
    if (acc_ev) begin
      next_s.cnt_acc = s.cnt_acc + 1'b1;
    end

    // Host reads: data and enable are both registered and appear together one cycle after the read
    if (rd) begin
      unique case (ofs)
        OFS_DATA: begin
          next_s.dout    = s.bp ? word_cur[7:0] : word_cur[15:8];
          next_s.dout_en = 1'b1;
          next_s.bp      = !s.bp;
        end
        OFS_CMD: begin
          next_s.dout    = status;
          next_s.dout_en = 1'b1;
        end
        OFS_PIN: begin
          next_s.dout    = parallel_input_byte;
          next_s.dout_en = 1'b1;
        end
        OFS_POUT: begin
          next_s.dout_en = 1'b0;
        end
      endcase
    end

    // Host writes
    if (wr) begin
      unique case (ofs)
        OFS_DATA: begin
          next_s.bp = !s.bp;
          if (s.grp == GRP_CTRL) begin
            if (s.elem == ELEM_MMODE) begin
              next_s.mmode = mem_wdata;
            end
          end else if (grp_ctr) begin
            mem_we = 1'b1;
            if ((s.grp == GRP_TB) && (s.elem == ELEM_LOAD)) begin
              next_s.load_tb = mem_wdata;
            end
            if ((s.grp == GRP_ACC) && (s.elem == ELEM_LOAD)) begin
              next_s.load_acc = mem_wdata;
            end
            if ((s.grp == GRP_ACC) && (s.elem == ELEM_MODE)) begin
              next_s.src_sel = mem_wdata[SRC_W-1:0];
            end
          end
        end
        OFS_CMD: begin
          unique case (op)
            OP_PTR: begin
              next_s.elem = io_din[4:3];
              next_s.grp  = io_din[2:0];
              next_s.bp   = 1'b1;
            end
            OP_ARM, OP_LOAD, OP_LDARM: begin
              // A bad interval refuses the whole command, no counter moves
              if (sel[SEL_TB] && op[1] && load_bad) begin
                next_s.err     = 1'b1;
                next_s.cnt_tb  = s.cnt_tb;
                next_s.cnt_acc = s.cnt_acc;
                next_s.outs    = s.outs;
              end else begin
                if (sel[SEL_TB] && op[1]) begin
                  next_s.cnt_tb = s.load_tb;
                  next_s.err    = 1'b0;
                end
                if (sel[SEL_ACC] && op[1]) begin
                  next_s.cnt_acc = s.load_acc;
                end
                if (sel[SEL_TB] && op[0]) begin
                  next_s.arm_tb = 1'b1;
                end
                if (sel[SEL_ACC] && op[0]) begin
                  next_s.arm_acc = 1'b1;
                end
              end
            end
            OP_DSAVE, OP_SAVE, OP_DISARM: begin
              if (op != OP_SAVE) begin
                next_s.arm_tb  = sel[SEL_TB] ? 1'b0 : s.arm_tb;
                next_s.arm_acc = sel[SEL_ACC] ? 1'b0 : s.arm_acc;
              end
              if (op != OP_DISARM) begin
                next_s.hold_tb  = sel[SEL_TB] ? s.cnt_tb : s.hold_tb;
                next_s.hold_acc = sel[SEL_ACC] ? s.cnt_acc : s.hold_acc;
              end
            end
            OP_MISC: begin
              if (io_din == CMD_MRESET) begin
                next_s.arm_tb  = 1'b0;
                next_s.arm_acc = 1'b0;
                next_s.outs    = '0;
                next_s.err     = 1'b0;
                next_s.mmode   = WORD_RST;
                next_s.bp      = 1'b1;
              end else if ((nsel >= 3'(SRC_FIRST)) && (nsel <= 3'(NUM_CTR))) begin
                // Only the addressed output bit moves; others are left alone
                if (io_din[4:3] == SUB_CLR) begin
                  next_s.outs[nsel - 3'(SRC_FIRST)] = 1'b0;
                end else if (io_din[4:3] == SUB_SET) begin
                  next_s.outs[nsel - 3'(SRC_FIRST)] = 1'b1;
                end
              end
            end
          endcase
        end
        OFS_PIN: begin
          next_s.pout = s.pout;
        end
        OFS_POUT: begin
          next_s.pout = io_din;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s          <= '0;
      s.bp       <= 1'b1;
      s.load_tb  <= WORD_RST;
      s.mmode    <= WORD_RST;
      s.pout     <= POUT_RST;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flops
  assign io_dout              = s.dout;
  assign io_dout_en           = s.dout_en;
  assign timebase_out         = s.outs[SEL_TB];
  assign parallel_output_byte = s.pout;
endmodule

/* verif/gfc_top_assertions.sv */
// Port checker for the gated frequency counter card
`timescale 1ns/10ps
module gfc_chk
  import gfc_pkg::*;
#(
  parameter int TICK_CYCLES = 20
) (
  // Clock and reset
  input wire logic                       mclk,
  input wire logic                       arst_n,
  // Host byte port
  input wire logic [gfc_pkg::ADDR_W-1:0] io_addr,
  input wire logic                       io_rd,
  input wire logic                       io_wr,
  input wire logic [7:0]                 io_din,
  input wire logic [7:0]                 io_dout,
  input wire logic                       io_dout_en,
  input wire logic [7:0]                 base_switch,
  // Field side
  input wire logic                       timebase_out,
  input wire logic [7:0]                 parallel_input_byte,
  input wire logic [7:0]                 parallel_output_byte
);
  // ----------
  // Decode
  // ----------
  logic       hit;
  logic [1:0] ofs;
  logic       rd_any;
  logic       rd_ok;
  logic       pw;
  // Switch values under the floor make the card ignore all host reads and writes
  assign hit    = io_addr[9:2] == base_switch && base_switch >= BASE_MIN;
  assign ofs    = io_addr[1:0];
  assign rd_any = io_rd && hit;
  assign rd_ok  = rd_any && ofs != OFS_POUT;
  assign pw     = io_wr && hit && ofs == OFS_POUT;
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ----------
  // Properties
  // ----------
  property p_rd_ans; rd_ok |=> io_dout_en; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read got no answer");
  property p_rd_none; rd_any && ofs == OFS_POUT |=> !io_dout_en; endproperty
  a_rd_none: assert property (p_rd_none) else $error("unused read answered");
  property p_en_cause; io_dout_en |-> $past(rd_ok); endproperty
  a_en_cause: assert property (p_en_cause) else $error("answer without decode");
  property p_pin_rd;
    rd_any && ofs == OFS_PIN |=> io_dout == $past(parallel_input_byte);
  endproperty
  a_pin_rd: assert property (p_pin_rd) else $error("input byte wrong");
  property p_stat_tb;
    rd_any && ofs == OFS_CMD |=> io_dout[SEL_TB+1] == $past(timebase_out);
  endproperty
  a_stat_tb: assert property (p_stat_tb) else $error("status timebase bit wrong");
  property p_pout_wr; pw |=> parallel_output_byte == $past(io_din); endproperty
  a_pout_wr: assert property (p_pout_wr) else $error("output byte not latched");
  property p_pout_hold; !pw |=> $stable(parallel_output_byte); endproperty
  a_pout_hold: assert property (p_pout_hold) else $error("output byte moved");
  property p_dout_hold; !rd_any |=> $stable(io_dout); endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("read data moved");
  // Main scenarios reached
  c_rd: cover property (rd_ok ##1 io_dout_en);
  c_tb: cover property ($rose(timebase_out));
  c_pw: cover property (pw);
endmodule

bind gfc_top gfc_chk #(.TICK_CYCLES(TICK_CYCLES)) gfc_chk_inst (
  .mclk(mclk), .arst_n(arst_n), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
  .io_din(io_din), .io_dout(io_dout), .io_dout_en(io_dout_en), .base_switch(base_switch),
  .timebase_out(timebase_out), .parallel_input_byte(parallel_input_byte),
  .parallel_output_byte(parallel_output_byte));

/* verif/gfc_host_model.sv */
// Host processor model issuing byte reads and writes to the card
`timescale 1ns/10ps
module gfc_host_model
  import gfc_pkg::*;
(
  // Clock and card base
  input wire logic                       mclk,
  input wire logic [7:0]                 base_sel,
  // Byte cycle strobes
  output logic     [gfc_pkg::ADDR_W-1:0] io_addr,
  output logic                           io_rd,
  output logic                           io_wr,
  output logic     [7:0]                 io_din,
  // Read answer
  input wire logic [7:0]                 io_dout
);
  // Quiet bus at time zero
  initial begin
    io_addr = '0;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_din = '0;
  end
  // One byte cycle; released lines show the inverse so stale values never look valid
  task automatic acc(input logic wr, input logic [9:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge mclk);
    io_addr <= a;
    io_din <= d;
    io_rd <= !wr;
    io_wr <= wr;
    @(posedge mclk);
    io_rd <= 1'b0;
    io_wr <= 1'b0;
    io_addr <= ~a;
    io_din <= ~d;
    @(posedge mclk);
    q = io_dout;
    // Recovery gap also covers the store read latency after pointer moves
    @(posedge mclk);
  endtask
  task automatic wr(input logic [1:0] o, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, {base_sel, o}, d, q);
  endtask
  task automatic rd(input logic [1:0] o, output logic [7:0] q);
    acc(1'b0, {base_sel, o}, 8'h00, q);
  endtask
endmodule

/* verif/tb.sv */
// Self-checking bench for the gated frequency counter card
`timescale 1ns/10ps
module tb;
  import gfc_pkg::*;
  // ----------
  // Signals
  // ----------
  localparam int TICK = 10; // Short tick: one millisecond step is ten clocks
  logic              mclk = 1'b0;
  logic              arst_n = 1'b0;
  logic [ADDR_W-1:0] io_addr;
  logic              io_rd;
  logic              io_wr;
  logic [7:0]        io_din;
  logic [7:0]        io_dout;
  logic              io_dout_en;
  logic [7:0]        base_switch;
  logic [7:0]        hbase;
  logic [7:0]        base0;
  logic [4:0]        count_src = '0;
  logic [3:0]        count_gate = '0;
  logic              timebase_out;
  logic [7:0]        parallel_input_byte = '0;
  logic [7:0]        parallel_output_byte;
  logic [8:0]        noise = '0;
  logic [8:0]        src_vec;
  logic [3:0]        sel_code = '0;
  logic              tgl = 1'b0;
  logic [15:0]       g_ms = 16'h0001;
  logic [15:0]       w1;
  logic [7:0]        e;
  logic [7:0]        m;
  logic [7:0]        dq;
  logic [7:0]        exp_q[$];
  logic [7:0]        msk_q[$];
  int                hi_cnt = 0;
  int                n_fail = 0;
  int                checks = 0;
  int                seed = 32'h46d0;

  always #25 mclk = ~mclk;

  gfc_top #(.TICK_CYCLES(TICK)) gfc_top_inst (.mclk(mclk), .arst_n(arst_n),
    .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_din(io_din), .io_dout(io_dout),
    .io_dout_en(io_dout_en), .base_switch(base_switch), .count_src(count_src),
    .count_gate(count_gate), .timebase_out(timebase_out),
    .parallel_input_byte(parallel_input_byte), .parallel_output_byte(parallel_output_byte));
  gfc_host_model gfc_host_model_inst (.mclk(mclk), .base_sel(hbase), .io_addr(io_addr),
    .io_rd(io_rd), .io_wr(io_wr), .io_din(io_din), .io_dout(io_dout));

  // ----------
  // Helpers
  // ----------
  task automatic cmp8(input string nm, input logic [7:0] ex, input logic [7:0] got,
                      input logic [7:0] mk);
    checks++;
    if (((got ^ ex) & mk) !== 8'h00) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic cmp16(input string nm, input logic [15:0] ex, input logic [15:0] got);
    checks++;
    if (got !== ex) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c);
    gfc_host_model_inst.wr(OFS_CMD, c);
  endtask
  // Words go out as byte pairs, low byte first
  task automatic wrw(input logic [15:0] w);
    gfc_host_model_inst.wr(OFS_DATA, w[7:0]);
    gfc_host_model_inst.wr(OFS_DATA, w[15:8]);
  endtask
  task automatic rdx(input logic [1:0] o, input logic [7:0] ex, input logic [7:0] mk);
    exp_q.push_back(ex);
    msk_q.push_back(mk);
    gfc_host_model_inst.rd(o, dq);
  endtask
  task automatic rdw(input logic [15:0] w);
    rdx(OFS_DATA, w[7:0], 8'hFF);
    rdx(OFS_DATA, w[15:8], 8'hFF);
  endtask
  // Bounded status poll; a level never reached shows as a mismatch
  task automatic poll(input logic lv);
    int k;
    k = 0;
    dq = {8{~lv}};
    while (dq[SEL_TB+1] !== lv && k < 300) begin
      rdx(OFS_CMD, 8'h00, 8'h00);
      k++;
    end
    cmp8("status_timebase", {3'h0, lv, 4'h0}, dq, 8'h10);
  endtask
  // Host measurement sequence; odd codes preload near the top to force a wrap
  task automatic measure(input logic [3:0] c);
    logic [15:0] ld;
    g_ms = 16'd2 + 16'($unsigned($random(seed)) % 3);
    noise = 9'($random(seed));
    sel_code = c;
    ld = c[0] ? 16'hFFFB : 16'h0000;
    cmd(8'h05);
    wrw({12'h000, c});
    cmd(8'h0D);
    wrw(ld);
    cmd(8'h0C);
    wrw(g_ms);
    cmd(8'h68);
    poll(1'b1);
    poll(1'b0);
    cmd(8'h70);
    poll(1'b1);
    poll(1'b0);
    // Disarm while the timebase is surely still low, so it cannot stick high
    cmd(8'hD8);
    cmd(8'hB0);
    cmd(8'h15);
    rdw(ld + 16'(g_ms * (TICK / 2)));
    cmd(8'hE4);
  endtask

  // ----------
  // Processes
  // ----------
  // Answers are matched in order against the notes left by the driver
  always @(posedge mclk) begin
    if (io_dout_en === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("FAIL io_dout_en expected 0 seen 1");
      end else begin
        e = exp_q.pop_front();
        m = msk_q.pop_front();
        if (m != 8'h00) cmp8("io_dout", e, io_dout, m);
      end
    end
  end
  // Selected input toggles every clock, the rest hold a random level
  always @(posedge mclk) begin
    tgl <= ~tgl;
    src_vec = noise;
    if (sel_code != 4'h0) src_vec[sel_code - 4'h1] = tgl;
    {count_gate, count_src} <= src_vec;
  end
  // Each high phase of the timebase must last the programmed interval
  always @(posedge mclk) begin
    if (timebase_out === 1'b1) hi_cnt <= hi_cnt + 1;
    else if (hi_cnt != 0) begin
      cmp16("timebase_high", 16'(g_ms * TICK), 16'(hi_cnt));
      hi_cnt <= 0;
    end
  end
  // Watchdog, far beyond the longest expected run
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    $display("FAIL watchdog expected done seen timeout");
    tally_and_finish;
  end

  initial begin
    base_switch = BASE_MIN + 8'($unsigned($random(seed)) % 192);
    hbase = base_switch;
    base0 = base_switch;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    cmp8("parallel_output_byte", POUT_RST, parallel_output_byte, 8'hFF);
    e = 8'($random(seed));
    gfc_host_model_inst.wr(OFS_POUT, e);
    cmp8("parallel_output_byte", e, parallel_output_byte, 8'hFF);
    gfc_host_model_inst.wr(OFS_PIN, ~e);
    cmp8("parallel_output_byte", e, parallel_output_byte, 8'hFF);
    parallel_input_byte <= 8'($random(seed));
    @(posedge mclk);
    rdx(OFS_PIN, parallel_input_byte, 8'hFF);
    gfc_host_model_inst.rd(OFS_POUT, dq);
    // Foreign base, then a base below the floor: neither may answer
    hbase <= base_switch ^ 8'h80;
    @(posedge mclk);
    gfc_host_model_inst.rd(OFS_PIN, dq);
    base_switch <= 8'h3F;
    hbase <= 8'h3F;
    @(posedge mclk);
    gfc_host_model_inst.rd(OFS_PIN, dq);
    // Back to the original base for the rest of the run
    base_switch <= base0;
    hbase <= base0;
    @(posedge mclk);
    w1 = 16'($random(seed));
    cmd(8'h09);
    wrw(w1);
    // Out-of-range intervals are refused and leave the timebase idle
    for (int i = 0; i < 2; i++) begin
      cmd(8'h0C);
      wrw(i == 0 ? 16'h0000 : 16'h8000);
      cmd(8'h68);
      rdx(OFS_CMD, 8'h80, 8'h80);
    end
    repeat (4 * TICK) @(posedge mclk);
    cmp8("timebase_out", 8'h00, {7'h00, timebase_out}, 8'h01);
    cmd(CMD_MRESET);
    rdx(OFS_CMD, 8'h01, 8'hC1);
    cmd(8'h04);
    wrw(16'h0000);
    for (int c = 1; c <= 9; c++) measure(4'(c));
    cmd(8'h09);
    rdw(w1);
    tally_and_finish;
  end
endmodule
